/* common/qshp_pkg.sv */
`default_nettype none
package qshp_pkg;
	// =====================================================
	// Lane width codes
	localparam logic [1:0] WID_SINGLE = 2'h0;
	localparam logic [1:0] WID_DUAL = 2'h1;
	localparam logic [1:0] WID_QUAD = 2'h2;
	// =====================================================
	// First byte of each command transaction
	localparam logic [7:0] CMD_STANDBY = 8'h41;
	localparam logic [7:0] CMD_SLEEP = 8'h42;
	localparam logic [7:0] CMD_OFF_A = 8'h43;
	localparam logic [7:0] CMD_OFF_B = 8'h50;
	localparam logic [7:0] CMD_EXT_SRC = 8'h44;
	localparam logic [7:0] CMD_INT_OSC = 8'h48;
	localparam logic [7:0] CMD_PLL_A = 8'h61;
	localparam logic [7:0] CMD_PLL_B = 8'h62;
	localparam logic [7:0] CMD_CORE_RST = 8'h68;
	localparam logic [7:0] CMD_PAD_DRV = 8'h70;
	localparam logic [7:0] CMD_PAD_SLP = 8'h71;
	// =====================================================
	// Parameter field limits
	localparam int NGRP = 26;
	localparam logic [5:0] GRP_LAST = 6'h19;
	localparam logic [5:0] GRP_RSV_LO = 6'h04;
	localparam logic [5:0] GRP_RSV_HI = 6'h07;
	localparam logic [5:0] MULT_RSV = 6'h01;
	localparam logic [5:0] MULT_MAX = 6'h06;
	localparam logic [1:0] PDS_RSV = 2'h3;
	// =====================================================
	// Reset values
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] PLL_RST = 8'h00;
	localparam logic [5:0] PIN_RST = 6'h10;
	// =====================================================
	// Types
	typedef enum logic [2:0] {PH_IDLE = 3'h0, PH_HDR = 3'h1, PH_DUM = 3'h3, PH_RDAT = 3'h2,
		PH_WDAT = 3'h6, PH_CMD = 3'h7, PH_SKIP = 3'h5} qshp_ph_e;
	typedef enum logic [1:0] {PW_SLEEP = 2'h0, PW_ACTIVE = 2'h1, PW_STANDBY = 2'h3,
		PW_OFF = 2'h2} qshp_pwr_e;
	typedef struct packed {
		logic [21:0] addr;
		logic [7:0] data;
	} qshp_wr_s;
	typedef struct packed {
		logic [2:0][5:0] sy;
		logic [5:0] f;
		qshp_ph_e ph;
		logic [1:0] wid;
		logic [7:0] rx_sh;
		logic [2:0] rx_cnt;
		logic [1:0] nb;
		logic [7:0] hdr;
		logic [7:0] prm;
		logic [21:0] addr;
		logic [7:0] tx_sh;
		logic [2:0] tx_cnt;
		logic [7:0] tx_buf;
		logic [3:0] dq_o;
		logic [3:0] oe;
		logic rd_req;
		logic [21:0] rd_a;
		logic rd_pend;
		logic rd_flag;
		logic [7:0] fl;
		qshp_pwr_e pwr;
		logic clk_ext;
		logic [7:0] pll;
		logic [NGRP-1:0][2:0] drv;
		logic [NGRP-1:0][1:0] pds;
		logic core_rst;
		logic [1:0] zrd;
		logic push;
		qshp_wr_s pw;
		logic done;
	} qshp_st_s;
endpackage : qshp_pkg
`default_nettype wire

/* hw/qshp_slave.sv */
// Overview of operation
// - In dual or quad mode every lane is an input when chip select falls.
// - Device drives only from first read data bit; dummy byte is undriven.
// - Chip select high returns every lane to input.
// - Dual: master-in carries the MSB; quad: lane three down to master-out.
// - Reads and writes address a 4 megabyte space.
// - Fields go MSB first; transactions are framed by chip select low.
// - Any number of data bytes, address advancing by one per byte.
// - Read is 00, 22-bit address, dummy byte, then one data byte per byte.
// - Write is 10, 22-bit address, data; complete when chip select rises.
// - Command is 01 plus 6-bit code, parameter byte, then 00h.
// - Commands run only in single lane mode, except core reset.
// - Core power-off restores command defaults except pad sleep states.
// - Command 00h or two reads of address 0 wake to active.
// - 41h standby, 42h sleep, 43h or 50h core power off.
// - 44h external source, 48h internal oscillator; reset only on change.
// - 61h/62h sets PLL ratio, only in sleep, multiplier 0 or 2 to 6.
// - 68h pulses core reset, keeping command settings.
// - 71h sets pad power-down state per group; cleared only by reset.
// - Interrupt pin floats when disabled, else low on any unmasked flag.
// - Flags are set by sources and all cleared by a read of the flag address.
// - After reset single lane; width code 00, 01, 10.
// - Only clock mode 0 is supported.
`timescale 1ns/100ps
`default_nettype none
module qshp_fifo #(
	parameter int W = 30,
	parameter int D = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} qshp_fs_s;
	qshp_fs_s s, n;
	logic [W-1:0] mem [D];
	logic wr, rd;
	// Pointers wrap freely, so depth must be a power of two
	if (D < 2 || (D & (D - 1)) != 0)
	begin : g_chk
		$error("fifo depth must be a power of two");
	end
	assign in_ready = s.cnt != (AW+1)'(D);
	assign out_valid = s.cnt != '0;
	assign wr = in_valid & in_ready;
	assign rd = out_valid & out_ready;
	assign out_data = mem[s.rp];
	// Pointer and fill count update
	always_comb
	begin
		n = s;
		if (wr)
			n.wp = s.wp + 1'b1;
		if (rd)
			n.rp = s.rp + 1'b1;
		if (wr && !rd)
			n.cnt = s.cnt + 1'b1;
		else if (rd && !wr)
			n.cnt = s.cnt - 1'b1;
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s <= '0;
		else
			s <= n;
	end
	// Storage has no reset; only written words are ever read
	always_ff @(posedge clk)
	begin
		if (wr)
			mem[s.wp] <= in_data;
	end
endmodule : qshp_fifo

module qshp_slave #(
	parameter logic [21:0] FLAG_ADDR = 22'h302010,
	parameter int FIFO_DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk_pin,
	input wire logic cs_n_pin,
	input wire logic [3:0] dq_in,
	output logic [3:0] dq_out,
	output logic [3:0] dq_oe,
	input wire logic [1:0] lane_width,
	output logic rd_req,
	output logic [21:0] rd_addr,
	input wire logic [7:0] rd_data,
	output logic wr_valid,
	input wire logic wr_ready,
	output logic [21:0] wr_addr,
	output logic [7:0] wr_data,
	output logic wr_fifo_ready,
	output logic wr_done,
	input wire logic [7:0] irq_set,
	input wire logic int_en,
	input wire logic [7:0] int_mask,
	input wire logic int_push_pull,
	output logic int_n_out,
	output logic int_n_oe,
	output logic [1:0] pwr_state,
	output logic clk_ext_sel,
	output logic [7:0] pll_ratio,
	output logic core_rst,
	output logic [3*qshp_pkg::NGRP-1:0] pad_drive,
	output logic [2*qshp_pkg::NGRP-1:0] pad_sleep
);
	qshp_pkg::qshp_st_s s, n;
	qshp_pkg::qshp_wr_s fo;
	logic [5:0] fnew;
	logic bdone, clr, int_act;
	logic [7:0] sh;
	logic [5:0] grp;

	// =====================================================
	// Lane helpers
	function automatic logic [2:0] lanes_k(input logic [1:0] w);
		case (w)
			qshp_pkg::WID_DUAL: lanes_k = 3'h2;
			qshp_pkg::WID_QUAD: lanes_k = 3'h4;
			default: lanes_k = 3'h1;
		endcase
	endfunction : lanes_k

	function automatic logic [7:0] shin(input logic [7:0] v, input logic [3:0] d,
		input logic [1:0] w);
		case (w)
			qshp_pkg::WID_DUAL: shin = {v[5:0], d[1:0]};
			qshp_pkg::WID_QUAD: shin = {v[3:0], d};
			default: shin = {v[6:0], d[0]};
		endcase
	endfunction : shin

	function automatic logic [3:0] pins(input logic [7:0] v, input logic [1:0] w);
		case (w)
			qshp_pkg::WID_DUAL: pins = {2'h0, v[7:6]};
			qshp_pkg::WID_QUAD: pins = v[7:4];
			default: pins = {2'h0, v[7], 1'h0};
		endcase
	endfunction : pins

	function automatic logic [3:0] oemask(input logic [1:0] w);
		case (w)
			qshp_pkg::WID_DUAL: oemask = 4'h3;
			qshp_pkg::WID_QUAD: oemask = 4'hF;
			default: oemask = 4'h2;
		endcase
	endfunction : oemask

	// =====================================================
	// Next state
	always_comb
	begin
		n = s;
		bdone = 1'b0;
		sh = s.tx_sh;
		grp = s.rx_sh[7:2];
		// Pins pass three stages; a bit moves once stages two and three agree
		fnew = (s.sy[1] & s.sy[2]) | (s.f & (s.sy[1] | s.sy[2]));
		n.sy = {s.sy[1:0], {sclk_pin, cs_n_pin, dq_in}};
		n.f = fnew;
		n.rd_req = 1'b0;
		n.core_rst = 1'b0;
		n.push = 1'b0;
		n.done = 1'b0;
		n.rd_pend = s.rd_req;
		// Set wins over the read clear
		clr = s.rd_pend & s.rd_flag;
		n.fl = (s.fl & ~{8{clr}}) | irq_set;
		if (s.rd_pend)
			n.tx_buf = s.rd_flag ? s.fl : rd_data;
		if (s.f[4] && !fnew[4])
		begin
			// Frame start: all lanes input, width latched for the frame
			n.ph = qshp_pkg::PH_HDR;
			n.rx_cnt = 3'h0;
			n.nb = 2'h0;
			n.tx_cnt = 3'h0;
			n.oe = 4'h0;
			n.wid = (lane_width == 2'h3) ? qshp_pkg::WID_SINGLE : lane_width;
		end
		else if (!s.f[4] && fnew[4])
		begin
			n.ph = qshp_pkg::PH_IDLE;
			n.oe = 4'h0;
			n.done = s.ph == qshp_pkg::PH_WDAT;
			// Three zero bytes then frame end is the wake command
			if (s.ph == qshp_pkg::PH_DUM && s.rx_cnt == 3'h0 && s.addr == 22'h0
				&& s.wid == qshp_pkg::WID_SINGLE)
				n.pwr = qshp_pkg::PW_ACTIVE;
		end
		else if (!fnew[4] && s.ph != qshp_pkg::PH_IDLE)
		begin
			// Mode 0: sample on rising, shift out on falling
			if (fnew[5] && !s.f[5])
			begin
				n.rx_sh = shin(s.rx_sh, fnew[3:0], s.wid);
				n.rx_cnt = s.rx_cnt + lanes_k(s.wid);
				bdone = n.rx_cnt == 3'h0;
			end
			else if (!fnew[5] && s.f[5] && s.ph == qshp_pkg::PH_RDAT)
			begin
				if (s.tx_cnt == 3'h0)
					sh = s.tx_buf;
				n.dq_o = pins(sh, s.wid);
				n.oe = oemask(s.wid);
				n.tx_sh = sh << lanes_k(s.wid);
				n.tx_cnt = s.tx_cnt + lanes_k(s.wid);
			end
		end
		// Byte decode
		if (bdone)
		begin
			case (s.ph)
				qshp_pkg::PH_HDR:
				begin
					n.nb = s.nb + 2'h1;
					case (s.nb)
						2'h0:
						begin
							n.hdr = n.rx_sh;
							n.addr[21:16] = n.rx_sh[5:0];
							if (n.rx_sh[7:6] == 2'h1)
								n.ph = qshp_pkg::PH_CMD;
							else if (n.rx_sh[7:6] == 2'h3)
								n.ph = qshp_pkg::PH_SKIP;
						end
						2'h1: n.addr[15:8] = n.rx_sh;
						default:
						begin
							n.addr[7:0] = n.rx_sh;
							n.ph = s.hdr[7] ? qshp_pkg::PH_WDAT : qshp_pkg::PH_DUM;
						end
					endcase
				end
				qshp_pkg::PH_DUM, qshp_pkg::PH_RDAT:
				begin
					// Fetch one byte ahead of each host byte
					n.ph = qshp_pkg::PH_RDAT;
					n.rd_req = 1'b1;
					n.rd_a = s.addr;
					n.rd_flag = s.addr == FLAG_ADDR;
					n.addr = s.addr + 22'h1;
					if (s.ph == qshp_pkg::PH_DUM)
					begin
						n.zrd = (s.addr == 22'h0) ? s.zrd + 2'h1 : 2'h0;
						if (n.zrd == 2'h2)
						begin
							n.zrd = 2'h0;
							n.pwr = qshp_pkg::PW_ACTIVE;
						end
					end
				end
				qshp_pkg::PH_WDAT:
				begin
					n.push = 1'b1;
					n.pw = '{addr: s.addr, data: n.rx_sh};
					n.addr = s.addr + 22'h1;
				end
				qshp_pkg::PH_CMD:
				begin
					n.nb = s.nb + 2'h1;
					if (s.nb == 2'h1)
						n.prm = n.rx_sh;
					else
					begin
						n.ph = qshp_pkg::PH_SKIP;
						grp = s.prm[7:2];
						// Only core reset passes in dual or quad mode
						if (s.wid == qshp_pkg::WID_SINGLE || s.hdr == qshp_pkg::CMD_CORE_RST)
						begin
							case (s.hdr)
								qshp_pkg::CMD_STANDBY: n.pwr = qshp_pkg::PW_STANDBY;
								qshp_pkg::CMD_SLEEP: n.pwr = qshp_pkg::PW_SLEEP;
								qshp_pkg::CMD_OFF_A, qshp_pkg::CMD_OFF_B:
								begin
									n.pwr = qshp_pkg::PW_OFF;
									n.clk_ext = 1'b0;
									n.pll = qshp_pkg::PLL_RST;
									n.drv = '0;
								end
								qshp_pkg::CMD_EXT_SRC:
								begin
									n.clk_ext = 1'b1;
									n.core_rst = !s.clk_ext;
								end
								qshp_pkg::CMD_INT_OSC:
								begin
									n.clk_ext = 1'b0;
									n.core_rst = s.clk_ext;
								end
								qshp_pkg::CMD_PLL_A, qshp_pkg::CMD_PLL_B:
								begin
									if (s.pwr == qshp_pkg::PW_SLEEP && s.prm[5:0] != qshp_pkg::MULT_RSV
										&& s.prm[5:0] <= qshp_pkg::MULT_MAX)
										n.pll = s.prm;
								end
								qshp_pkg::CMD_CORE_RST: n.core_rst = 1'b1;
								qshp_pkg::CMD_PAD_DRV:
								begin
									if (grp <= qshp_pkg::GRP_LAST
										&& (grp < qshp_pkg::GRP_RSV_LO || grp > qshp_pkg::GRP_RSV_HI))
										n.drv[grp] = {1'b1, s.prm[1:0]};
								end
								qshp_pkg::CMD_PAD_SLP:
								begin
									if (grp <= qshp_pkg::GRP_LAST && s.prm[1:0] != qshp_pkg::PDS_RSV
										&& (grp < qshp_pkg::GRP_RSV_LO || grp > qshp_pkg::GRP_RSV_HI))
										n.pds[grp] = s.prm[1:0];
								end
								default: n.ph = qshp_pkg::PH_SKIP;
							endcase
						end
					end
				end
				default: n.ph = s.ph;
			endcase
		end
	end

	// Pad sleep states clear only on the async reset, which also resets all else
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s <= '0;
			s.sy <= {3{qshp_pkg::PIN_RST}};
			s.f <= qshp_pkg::PIN_RST;
			s.ph <= qshp_pkg::PH_IDLE;
			s.pwr <= qshp_pkg::PW_SLEEP;
			s.fl <= qshp_pkg::FLAGS_RST;
			s.pll <= qshp_pkg::PLL_RST;
		end
		else
			s <= n;
	end

	// =====================================================
	// Write buffer: the memory side may stall, the serial side cannot
	qshp_fifo #(.W($bits(qshp_pkg::qshp_wr_s)), .D(FIFO_DEPTH)) u_wbuf (
		.clk(clk),
		.rst(rst),
		.in_valid(s.push),
		.in_ready(wr_fifo_ready),
		.in_data(s.pw),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data(fo)
	);

	// =====================================================
	// Outputs; interrupt pin is open drain unless push-pull chosen
	assign int_act = int_en & |(s.fl & int_mask);
	assign int_n_out = ~int_act;
	assign int_n_oe = int_en & (int_push_pull | int_act);
	assign dq_out = s.dq_o;
	assign dq_oe = s.oe;
	assign rd_req = s.rd_req;
	assign rd_addr = s.rd_a;
	assign wr_addr = fo.addr;
	assign wr_data = fo.data;
	assign wr_done = s.done;
	assign pwr_state = s.pwr;
	assign clk_ext_sel = s.clk_ext;
	assign pll_ratio = s.pll;
	assign core_rst = s.core_rst;
	assign pad_drive = s.drv;
	assign pad_sleep = s.pds;

	// =====================================================
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	a_lanes_idle_cs: assert property (s.f[4] |-> s.oe == 4'h0)
		else $error("lane driven while deselected");
	a_lanes_frame_start: assert property ($fell(s.f[4])
		|-> s.oe == 4'h0 && s.ph == qshp_pkg::PH_HDR)
		else $error("frame did not start with lanes as inputs");
	a_drive_data_only: assert property (s.oe != 4'h0 |-> s.ph == qshp_pkg::PH_RDAT)
		else $error("lane driven outside read data");
	a_lane_set_width: assert property (s.oe != 4'h0
		|-> s.oe == (s.wid == qshp_pkg::WID_QUAD ? 4'hF
			: s.wid == qshp_pkg::WID_DUAL ? 4'h3 : 4'h2))
		else $error("wrong lanes driven");
	a_power_single_lane: assert property ($changed(s.pwr)
		|-> $past(s.wid) == qshp_pkg::WID_SINGLE)
		else $error("power command taken outside single mode");
	a_ratio_in_sleep: assert property ($changed(s.pll)
		|-> $past(s.pwr) == qshp_pkg::PW_SLEEP || s.pll == qshp_pkg::PLL_RST)
		else $error("ratio changed outside sleep");
	a_off_defaults: assert property ($rose(s.pwr == qshp_pkg::PW_OFF)
		|-> !s.clk_ext && s.pll == qshp_pkg::PLL_RST && s.drv == '0)
		else $error("defaults not restored at power off");
	a_flag_read_clear: assert property (s.rd_pend && s.rd_flag |=> s.fl == $past(irq_set))
		else $error("flags not cleared by read");
	a_int_pin_level: assert property (int_en && (s.fl & int_mask) != 8'h0
		|-> int_n_oe && !int_n_out)
		else $error("interrupt pin not asserted");
	a_addr_step: assert property (bdone
		&& (s.ph == qshp_pkg::PH_WDAT || s.ph == qshp_pkg::PH_RDAT)
		|=> s.addr == $past(s.addr) + 22'h1)
		else $error("address did not advance");
	a_write_done: assert property ($rose(s.f[4])
		&& $past(s.ph) == qshp_pkg::PH_WDAT |-> s.done)
		else $error("write end not flagged");
	c_quad_read: cover property ($rose(s.oe == 4'hF));
	c_write_push: cover property (s.push ##[1:40] s.done);
	c_core_reset: cover property (s.core_rst);
endmodule : qshp_slave
`default_nettype wire

/* tb/qshp_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ======
// Host master: mode 0, clock parked low between frames
module qshp_host_model (
	input wire logic clk,
	input wire logic [3:0] lanes,
	output logic sclk_pin,
	output logic cs_n_pin,
	output logic [3:0] host_dq,
	output logic [3:0] host_oe
);
	// Idle: deselected, lanes released to the pull-ups
	initial
	begin
		sclk_pin = 1'b0;
		cs_n_pin = 1'b1;
		host_dq = 4'h0;
		host_oe = 4'h0;
	end

	// Frame opens on select low
	task automatic frame_on();
		@(posedge clk);
		cs_n_pin <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : frame_on

	// Frame closes with clock low; lanes released, then a long gap
	task automatic frame_off();
		repeat (4) @(posedge clk);
		cs_n_pin <= 1'b1;
		host_oe <= 4'h0;
		repeat (12) @(posedge clk);
	endtask : frame_off

	// One byte, w lanes, MSB first; data set while clock low
	// With drv low the host leaves every lane undriven
	// Sampled at the end of the high phase, well after the slave's update lag
	task automatic xfer(input logic [7:0] tx, input int w, input bit drv,
		output logic [7:0] rx);
		logic [3:0] v;
		rx = 8'h00;
		for (int k = 8 / w - 1; k >= 0; k--)
		begin
			v = 4'((tx >> (k * w)) & ((1 << w) - 1));
			@(posedge clk);
			host_oe <= drv ? 4'((1 << w) - 1) : 4'h0;
			host_dq <= v;
			repeat (3) @(posedge clk);
			sclk_pin <= 1'b1;
			repeat (4) @(posedge clk);
			rx = 8'((rx << w) | ((w == 1) ? 4'(lanes[1]) : (lanes & 4'((1 << w) - 1))));
			sclk_pin <= 1'b0;
		end
	endtask : xfer
endmodule : qshp_host_model
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam logic [21:0] FLAG_A = 22'h302010;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sclk_pin, cs_n_pin, rd_req, wr_valid, wr_fifo_ready, wr_done, core_rst;
	logic int_n_out, int_n_oe, clk_ext_sel;
	logic wr_ready = 1'b0;
	logic int_en = 1'b0;
	logic int_push_pull = 1'b0;
	logic [3:0] host_dq, host_oe, lanes, dq_out, dq_oe;
	logic [1:0] lane_width = 2'h0;
	logic [1:0] pwr_state;
	logic [21:0] rd_addr, wr_addr, a;
	logic [7:0] rd_data = 8'h00;
	logic [7:0] irq_set = 8'h00;
	logic [7:0] int_mask = 8'h00;
	logic [7:0] wr_data, pll_ratio, rx, flag_exp;
	logic [3*qshp_pkg::NGRP-1:0] pad_drive;
	logic [2*qshp_pkg::NGRP-1:0] pad_sleep;
	logic [7:0] mem [logic [21:0]];
	logic [7:0] emem [logic [21:0]];
	logic [29:0] wq [$];
	logic [29:0] got_q [$];
	int err_total = 0, compares = 0, cyc = 0, rst_cnt = 0, done_cnt = 0, bad_drv = 0, n;
	bit no_drive = 1'b0;

	// ======
	// Lane wires: slave, host, else pull-up
	assign lanes = (dq_oe & dq_out) | (~dq_oe & host_oe & host_dq) | (~dq_oe & ~host_oe);

	qshp_host_model host (.clk(clk), .lanes(lanes), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
		.host_dq(host_dq), .host_oe(host_oe));
	qshp_slave #(.FLAG_ADDR(FLAG_A), .FIFO_DEPTH(32)) uut (.clk(clk), .rst(rst),
		.sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .dq_in(lanes), .dq_out(dq_out), .dq_oe(dq_oe),
		.lane_width(lane_width), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
		.wr_fifo_ready(wr_fifo_ready), .wr_done(wr_done), .irq_set(irq_set), .int_en(int_en),
		.int_mask(int_mask), .int_push_pull(int_push_pull), .int_n_out(int_n_out),
		.int_n_oe(int_n_oe), .pwr_state(pwr_state), .clk_ext_sel(clk_ext_sel),
		.pll_ratio(pll_ratio), .core_rst(core_rst), .pad_drive(pad_drive), .pad_sleep(pad_sleep));

	// 50 ns system clock
	initial
		forever #25 clk = ~clk;

	// Memory model, event counters and the hang limit
	always @(posedge clk)
	begin
		if (rd_req === 1'b1)
			rd_data <= mem.exists(rd_addr) ? mem[rd_addr] : dflt(rd_addr);
		if (wr_valid === 1'b1 && wr_ready === 1'b1)
		begin
			got_q.push_back({wr_addr, wr_data});
			mem[wr_addr] = wr_data;
		end
		if (core_rst === 1'b1)
			rst_cnt++;
		if (wr_done === 1'b1)
			done_cnt++;
		if (no_drive && dq_oe !== 4'h0)
			bad_drv++;
		cyc++;
		if (cyc == 60000)
		begin
			err_total++;
			results();
		end
	end

	// ======
	// Helpers
	function automatic int lw();
		return (lane_width == 2'h2) ? 4 : (lane_width == 2'h1) ? 2 : 1;
	endfunction : lw

	function automatic logic [7:0] dflt(input logic [21:0] x);
		return x[7:0] ^ x[15:8] ^ 8'hA5;
	endfunction : dflt

	function automatic logic [7:0] expb(input logic [21:0] x);
		return (x == FLAG_A) ? flag_exp : emem.exists(x) ? emem[x] : dflt(x);
	endfunction : expb

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic hdr(input logic [1:0] ty, input logic [21:0] x);
		host.frame_on();
		host.xfer({ty, x[21:16]}, lw(), 1'b1, rx);
		host.xfer(x[15:8], lw(), 1'b1, rx);
		host.xfer(x[7:0], lw(), 1'b1, rx);
	endtask : hdr

	// Write burst; bytes past keep are expected to be dropped by a full buffer
	task automatic wrb(input logic [21:0] x, input int cnt, input int keep);
		logic [7:0] b;
		hdr(2'b10, x);
		for (int i = 0; i < cnt; i++)
		begin
			b = 8'($urandom);
			if (i < keep)
			begin
				wq.push_back({22'(x + i), b});
				emem[22'(x + i)] = b;
			end
			host.xfer(b, lw(), 1'b1, rx);
		end
		host.frame_off();
	endtask : wrb

	// Read burst; slave must stay off the lanes through header and dummy
	task automatic rdb(input logic [21:0] x, input int cnt);
		no_drive = 1'b1;
		hdr(2'b00, x);
		host.xfer(8'h00, lw(), lw() == 1, rx);
		no_drive = 1'b0;
		for (int i = 0; i < cnt; i++)
		begin
			host.xfer(8'h00, lw(), lw() == 1, rx);
			chk("rd_byte", expb(22'(x + i)), rx);
		end
		host.frame_off();
		chk("dq_oe_idle", 4'h0, dq_oe);
	endtask : rdb

	task automatic cmd(input logic [7:0] c, input logic [7:0] p);
		host.frame_on();
		host.xfer(c, lw(), 1'b1, rx);
		host.xfer(p, lw(), 1'b1, rx);
		host.xfer(8'h00, lw(), 1'b1, rx);
		host.frame_off();
	endtask : cmd

	// Drain with a stalling consumer, then compare in order
	task automatic fifo_chk();
		for (int t = 0; t < 3000 && got_q.size() < wq.size(); t++)
		begin
			@(posedge clk);
			wr_ready <= 1'($urandom);
		end
		@(posedge clk);
		wr_ready <= 1'b0;
		repeat (2) @(posedge clk);
		while (wq.size() > 0)
			chk("fifo_word", wq.pop_front(), (got_q.size() > 0) ? got_q.pop_front() : 'x);
		chk("fifo_empty", 1'b0, wr_valid);
	endtask : fifo_chk

	task automatic results();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results

	// ======
	// Main sequence
	initial
	begin
		n = $urandom(32'h498F34E8);
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		chk("pwr", 2'h0, pwr_state);
		chk("pll", 8'h00, pll_ratio);
		chk("ext", 1'b0, clk_ext_sel);
		chk("fifo_rdy", 1'b1, wr_fifo_ready);
		$display("test reset finished");
		// Full buffer refuses, then drains in order
		a = 22'($urandom) & 22'h3FFF00;
		n = done_cnt;
		wrb(a, 34, 32);
		chk("fifo_rdy", 1'b0, wr_fifo_ready);
		chk("wr_done", n + 1, done_cnt);
		fifo_chk();
		$display("test buffer finished");
		// Write then read back at each lane width
		for (int wi = 0; wi < 3; wi++)
		begin
			lane_width <= 2'(wi);
			a = 22'($urandom) & 22'h3FFFF0;
			wrb(a, 4, 4);
			fifo_chk();
			rdb(a, 4);
		end
		chk("undriven", 0, bad_drv);
		$display("test widths finished");
		// Commands in single lane mode
		lane_width <= 2'h0;
		cmd(8'h41, 8'h00);
		chk("pwr", 2'h3, pwr_state);
		cmd(8'h00, 8'h00);
		chk("pwr", 2'h1, pwr_state);
		cmd(8'h61, 8'h03);
		chk("pll", 8'h00, pll_ratio);
		cmd(8'h42, 8'h00);
		chk("pwr", 2'h0, pwr_state);
		cmd(8'h61, 8'h44);
		chk("pll", 8'h44, pll_ratio);
		cmd(8'h62, 8'h01);
		chk("pll", 8'h44, pll_ratio);
		n = rst_cnt;
		cmd(8'h44, 8'h00);
		chk("ext", 1'b1, clk_ext_sel);
		cmd(8'h44, 8'h00);
		cmd(8'h48, 8'h00);
		chk("ext", 1'b0, clk_ext_sel);
		chk("rst_pulses", n + 2, rst_cnt);
		cmd(8'h68, 8'h00);
		chk("rst_pulses", n + 3, rst_cnt);
		chk("pll", 8'h44, pll_ratio);
		cmd(8'h70, 8'h36);
		chk("pad_drv", 3'h6, pad_drive[41:39]);
		cmd(8'h71, 8'h09);
		chk("pad_slp", 2'h1, pad_sleep[5:4]);
		cmd(8'h43, 8'h00);
		chk("pwr", 2'h2, pwr_state);
		chk("pll", 8'h00, pll_ratio);
		chk("pad_drv", 3'h0, pad_drive[41:39]);
		chk("pad_slp", 2'h1, pad_sleep[5:4]);
		rdb(22'h0, 0);
		rdb(22'h0, 0);
		chk("pwr", 2'h1, pwr_state);
		cmd(8'h50, 8'h00);
		chk("pwr", 2'h2, pwr_state);
		cmd(8'h00, 8'h00);
		// Quad: only core reset is honoured
		lane_width <= 2'h2;
		n = rst_cnt;
		cmd(8'h41, 8'h00);
		chk("pwr", 2'h1, pwr_state);
		cmd(8'h68, 8'h00);
		chk("rst_pulses", n + 1, rst_cnt);
		$display("test commands finished");
		// Interrupt: masked source, unmasked source, clear by read
		lane_width <= 2'h0;
		int_en <= 1'b1;
		int_mask <= 8'h80;
		@(posedge clk) irq_set <= 8'h40;
		@(posedge clk) irq_set <= 8'h00;
		repeat (3) @(posedge clk);
		chk("int_n", 1'b1, int_n_out);
		irq_set <= 8'h80;
		@(posedge clk) irq_set <= 8'h00;
		repeat (3) @(posedge clk);
		chk("int_n", 1'b0, int_n_out);
		chk("int_oe", 1'b1, int_n_oe);
		flag_exp = 8'hC0;
		rdb(FLAG_A, 1);
		chk("int_n", 1'b1, int_n_out);
		// Push-pull pin drives high even with no flag pending
		int_push_pull <= 1'b1;
		repeat (2) @(posedge clk);
		chk("int_oe_pp", 1'b1, int_n_oe);
		chk("int_n_pp", 1'b1, int_n_out);
		int_en <= 1'b0;
		repeat (3) @(posedge clk);
		chk("int_oe", 1'b0, int_n_oe);
		$display("test interrupt finished");
		results();
	end
endmodule : tb
`default_nettype wire
